// ---- src/scrb_bank.sv ----
/*
  configuration register bank of a three source, one output link switch,
  reached by byte reads and writes from a serial slave front end.
  assumes the front end presents one-cycle requests synchronous to clk.
*/
`timescale 1ns/10ps
`include "scrb_defs.svh"
// Notes on behaviour
// - every register can be written and read back by the serial master.
// - the slave address low bit follows the strap pin held steady by the board.
// - the first serial access locks out the parallel pins until reset.
// - fast mode register at 0x00 resets to 0x40, enable bit 6, select bits 1:0.
// - fast enable low turns the fast channels off into standby.
// - fast select 00/01/10 picks source A/B/C and 11 must not be written.
// - side mode register at 0x01 resets to 0x40, enable bit 6, select bits 1:0.
// - side enable low opens the auxiliary switch.
// - pulse register at 0x11 resets to 0 and holds the A and B lane bits.
// - pulse register at 0x12 resets to 0 with C lane bits 3:0, upper bits zero.
// - input termination enable low disconnects all input terminations.
// - a set pulse bit opens that lane termination for 100 ms on a source change.
// - each equalization bit selects low (0) or high (1) equalization.
// - side select 00/01/10 picks source A/B/C and 11 must not be written.
module scrb_bank #(
  parameter int unsigned PULSE_CYCLES = `SCRB_PULSE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input scrb_pkg::scrb_req_t req,
  input wire logic slave_address_strap,
  input wire logic parallel_enable_pin,
  input wire logic [1:0] parallel_source_pins,
  output logic [7:0] rd_data_ff,
  output logic rd_valid_ff,
  output logic [6:0] slave_address_ff,
  output logic parallel_locked_ff,
  output scrb_pkg::scrb_link_t link_ff
);
  import scrb_pkg::*;

  logic [7:0] fast_ff, side_ff, rx_ff, pab_ff, pc_ff, eqab_ff, eqc_ff, tx_ff;
  logic [7:0] nxt_fast, nxt_side, nxt_rx, nxt_pab, nxt_pc, nxt_eqab, nxt_eqc, nxt_tx;
  logic nxt_locked;
  logic [7:0] nxt_rd_data;
  logic nxt_rd_valid;
  logic [6:0] nxt_addr;
  logic [1:0] src_prev_ff, nxt_src_prev;
  logic [1:0] eff_src;
  logic eff_en;
  logic src_change;
  logic [11:0] pulse_bits, pulse_open;
  scrb_link_t nxt_link;

  // register writes, masked to the implemented bits
  always_comb begin
    nxt_fast = fast_ff;
    nxt_side = side_ff;
    nxt_rx = rx_ff;
    nxt_pab = pab_ff;
    nxt_pc = pc_ff;
    nxt_eqab = eqab_ff;
    nxt_eqc = eqc_ff;
    nxt_tx = tx_ff;
    if (req.wr) begin
      unique case (req.addr)
        `SCRB_OFF_FAST_MODE: nxt_fast = req.data & `SCRB_MODE_MASK;
        `SCRB_OFF_SIDE_MODE: nxt_side = req.data & `SCRB_MODE_MASK;
        `SCRB_OFF_RX_SET: nxt_rx = req.data & `SCRB_RX_MASK;
        `SCRB_OFF_PULSE_AB: nxt_pab = req.data;
        `SCRB_OFF_PULSE_C: nxt_pc = req.data & `SCRB_LOW4_MASK;
        `SCRB_OFF_EQ_AB: nxt_eqab = req.data;
        `SCRB_OFF_EQ_C: nxt_eqc = req.data & `SCRB_LOW4_MASK;
        `SCRB_OFF_TX_SET: nxt_tx = req.data & `SCRB_TX_MASK;
        default: ;
      endcase
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    nxt_rd_valid = req.rd;
    nxt_rd_data = rd_data_ff;
    if (req.rd) begin
      unique case (req.addr)
        `SCRB_OFF_FAST_MODE: nxt_rd_data = fast_ff;
        `SCRB_OFF_SIDE_MODE: nxt_rd_data = side_ff;
        `SCRB_OFF_RX_SET: nxt_rd_data = rx_ff;
        `SCRB_OFF_PULSE_AB: nxt_rd_data = pab_ff;
        `SCRB_OFF_PULSE_C: nxt_rd_data = pc_ff;
        `SCRB_OFF_EQ_AB: nxt_rd_data = eqab_ff;
        `SCRB_OFF_EQ_C: nxt_rd_data = eqc_ff;
        `SCRB_OFF_TX_SET: nxt_rd_data = tx_ff;
        default: nxt_rd_data = 8'h00;
      endcase
    end
  end

  // lockout of the parallel pins and the strapped address
  always_comb begin
    nxt_locked = parallel_locked_ff | req.wr | req.rd;
    nxt_addr = {`SCRB_ADDR_HIGH, slave_address_strap};
  end

  // effective enable and source: parallel pins until locked, then registers
  always_comb begin
    eff_en = parallel_locked_ff ? fast_ff[`SCRB_EN_BIT] : parallel_enable_pin;
    eff_src = parallel_locked_ff ? fast_ff[1:0] : parallel_source_pins;
    nxt_src_prev = eff_src;
    src_change = (eff_src != src_prev_ff);
    pulse_bits = {pc_ff[3:0], pab_ff};
  end

  // one timer per lane, triggered on a source change when its bit is set
  for (genvar i = 0; i < 12; i++) begin : g_lane
    scrb_pulse_timer #(
      .CYCLES(PULSE_CYCLES)
    ) u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .trigger(src_change & pulse_bits[i]),
      .open_ff(pulse_open[i])
    );
  end

  // link settings presented to the analog side
  always_comb begin
    nxt_link.fast_path_enable = eff_en;
    nxt_link.fast_source_select = eff_src;
    nxt_link.side_enable = parallel_locked_ff ? side_ff[`SCRB_EN_BIT] : 1'b1;
    nxt_link.side_source_select = parallel_locked_ff ? side_ff[1:0] : parallel_source_pins;
    nxt_link.termination_connect = rx_ff[0] ? ~pulse_open : 12'h000;
    nxt_link.equalization_level_bits = {eqc_ff[3:0], eqab_ff};
    nxt_link.output_emphasis_level = tx_ff[3:2];
    nxt_link.output_termination_enable = tx_ff[1];
    nxt_link.output_current_select = tx_ff[0];
  end

  // register the state and the outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fast_ff <= `SCRB_RST_FAST_MODE;
      side_ff <= `SCRB_RST_SIDE_MODE;
      rx_ff <= `SCRB_RST_RX_SET;
      pab_ff <= `SCRB_RST_PULSE_AB;
      pc_ff <= `SCRB_RST_PULSE_C;
      eqab_ff <= `SCRB_RST_EQ_AB;
      eqc_ff <= `SCRB_RST_EQ_C;
      tx_ff <= `SCRB_RST_TX_SET;
      parallel_locked_ff <= 1'b0;
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
      slave_address_ff <= 7'h00;
      src_prev_ff <= 2'b00;
      link_ff <= '0;
    end else begin
      fast_ff <= nxt_fast;
      side_ff <= nxt_side;
      rx_ff <= nxt_rx;
      pab_ff <= nxt_pab;
      pc_ff <= nxt_pc;
      eqab_ff <= nxt_eqab;
      eqc_ff <= nxt_eqc;
      tx_ff <= nxt_tx;
      parallel_locked_ff <= nxt_locked;
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
      slave_address_ff <= nxt_addr;
      src_prev_ff <= nxt_src_prev;
      link_ff <= nxt_link;
    end
  end

  // assertions
  property p_rd_back;
    @(posedge clk) disable iff (!rst_n)
      (req.wr && req.addr == `SCRB_OFF_EQ_AB) ##1 (req.rd && req.addr == `SCRB_OFF_EQ_AB && !req.wr)
      |=> rd_valid_ff && rd_data_ff == $past(req.data, 2);
  endproperty
  a_rd_back: assert property (p_rd_back) else $error("read back mismatch");
  // skipped on the first edge after reset, where the register still holds its reset value
  property p_addr;
    @(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> slave_address_ff == {`SCRB_ADDR_HIGH, $past(slave_address_strap)};
  endproperty
  a_addr: assert property (p_addr) else $error("slave address wrong");
  property p_lock;
    @(posedge clk) disable iff (!rst_n) (req.wr || req.rd) |=> parallel_locked_ff [*4];
  endproperty
  a_lock: assert property (p_lock) else $error("lock lost");
  property p_fast_mask;
    @(posedge clk) disable iff (!rst_n) fast_ff[5:2] == 4'h0 && fast_ff[7] == 1'b0;
  endproperty
  a_fast_mask: assert property (p_fast_mask) else $error("fast mode reserved set");
  property p_en;
    @(posedge clk) disable iff (!rst_n)
      parallel_locked_ff |=> link_ff.fast_path_enable == $past(fast_ff[6]);
  endproperty
  a_en: assert property (p_en) else $error("fast enable wrong");
  property p_side;
    @(posedge clk) disable iff (!rst_n)
      parallel_locked_ff |=> link_ff.side_enable == $past(side_ff[6]);
  endproperty
  a_side: assert property (p_side) else $error("side enable wrong");
  property p_c_mask;
    @(posedge clk) disable iff (!rst_n) pc_ff[7:4] == 4'h0;
  endproperty
  a_c_mask: assert property (p_c_mask) else $error("pulse c upper set");
  property p_term_off;
    @(posedge clk) disable iff (!rst_n) !rx_ff[0] |=> link_ff.termination_connect == 12'h000;
  endproperty
  a_term_off: assert property (p_term_off) else $error("termination on");
  property p_pulse;
    @(posedge clk) disable iff (!rst_n)
      (src_change && pulse_bits[0] && rx_ff[0]) |-> ##2 !link_ff.termination_connect[0];
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse missing");
  c_write: cover property (@(posedge clk) disable iff (!rst_n) req.wr);
  c_read: cover property (@(posedge clk) disable iff (!rst_n) rd_valid_ff);
  c_switch: cover property (@(posedge clk) disable iff (!rst_n) src_change && |pulse_bits);
endmodule : scrb_bank

// ---- src/scrb_defs.svh ----
/*
  register offsets, reset values, field positions and timing constants
  of the switch configuration register bank. assumes nothing else.
*/
`ifndef SCRB_DEFS_SVH
`define SCRB_DEFS_SVH
`define SCRB_OFF_FAST_MODE 8'h00
`define SCRB_OFF_SIDE_MODE 8'h01
`define SCRB_OFF_RX_SET 8'h10
`define SCRB_OFF_PULSE_AB 8'h11
`define SCRB_OFF_PULSE_C 8'h12
`define SCRB_OFF_EQ_AB 8'h13
`define SCRB_OFF_EQ_C 8'h14
`define SCRB_OFF_TX_SET 8'h20
`define SCRB_RST_FAST_MODE 8'h40
`define SCRB_RST_SIDE_MODE 8'h40
`define SCRB_RST_RX_SET 8'h01
`define SCRB_RST_PULSE_AB 8'h00
`define SCRB_RST_PULSE_C 8'h00
`define SCRB_RST_EQ_AB 8'h00
`define SCRB_RST_EQ_C 8'h00
`define SCRB_RST_TX_SET 8'h03
`define SCRB_MODE_MASK 8'h43
`define SCRB_LOW4_MASK 8'h0F
`define SCRB_TX_MASK 8'h0F
`define SCRB_RX_MASK 8'h01
`define SCRB_EN_BIT 6
`define SCRB_ADDR_HIGH 6'h24
`define SCRB_PULSE_MS 100
`define SCRB_CLK_HZ 25000000
`define SCRB_PULSE_CYCLES ((`SCRB_PULSE_MS * (`SCRB_CLK_HZ / 1000)))
`endif

// ---- src/scrb_pkg.sv ----
/*
  types of the switch configuration register bank.
  assumes nothing from scrb_defs.svh; its numeric constants are written inline.
*/
package scrb_pkg;
  // write or read request from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } scrb_req_t;
  // settings that drive the analog link
  typedef struct packed {
    logic fast_path_enable;
    logic [1:0] fast_source_select;
    logic side_enable;
    logic [1:0] side_source_select;
    logic [11:0] termination_connect;
    logic [11:0] equalization_level_bits;
    logic [1:0] output_emphasis_level;
    logic output_termination_enable;
    logic output_current_select;
  } scrb_link_t;
  typedef enum logic [1:0] {
    SCRB_SRC_A = 2'b00,
    SCRB_SRC_B = 2'b01,
    SCRB_SRC_C = 2'b10
  } scrb_src_t;
endpackage : scrb_pkg

// ---- src/scrb_pulse_timer.sv ----
/*
  one channel termination pulse timer: opens the termination for a fixed
  count after a trigger. assumes a free running clock and sync reset.
*/
`timescale 1ns/10ps
module scrb_pulse_timer #(
  parameter int unsigned CYCLES = 2500000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic trigger,
  output logic open_ff
);
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic nxt_open;
  // reload on trigger, count down to zero
  always_comb begin
    nxt_cnt = cnt_ff;
    if (trigger) begin
      nxt_cnt = CYCLES;
    end else if (cnt_ff != 32'h0) begin
      nxt_cnt = cnt_ff - 32'h1;
    end
    nxt_open = (nxt_cnt != 32'h0);
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff <= 32'h0;
      open_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      open_ff <= nxt_open;
    end
  end
endmodule : scrb_pulse_timer

// ---- verif/scrb_master_model.sv ----
/*
  serial front end model: issues one-cycle byte writes and reads to the bank.
  assumes requests are sampled on the rising edge of clk.
*/
`timescale 1ns/10ps
module scrb_master_model (
  input wire logic clk,
  input wire logic [7:0] rd_data_ff,
  input wire logic rd_valid_ff,
  output scrb_pkg::scrb_req_t req
);
  import scrb_pkg::*;
  initial req = '0;
  // write request held for exactly one sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask : wr
  // read request, answer taken just after the edge that samples the request
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    v = rd_valid_ff;
    d = rd_data_ff;
  endtask : rd
  // write then read of one offset on consecutive edges, answer taken as in rd
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d,
    output logic v);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, wd};
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    v = rd_valid_ff;
    d = rd_data_ff;
  endtask : wr_rd
endmodule : scrb_master_model

// ---- verif/scrb_tb_top.sv ----
/*
  self-checking bench of the register bank with a serial master model.
  assumes the bank, its package and the master model are compiled first.
*/
`timescale 1ns/10ps
module scrb_tb_top;
  import scrb_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b0;
  logic pen = 1'b1;
  logic [1:0] psrc = 2'b01;
  scrb_req_t req;
  logic [7:0] rdd;
  logic rdv;
  logic [6:0] saddr;
  logic locked;
  scrb_link_t link;
  int mismatches = 0;
  int n_compared = 0;
  logic [31:0] lfsr = 32'h8B6A;
  logic [7:0] offs [9] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20, 8'h05};
  logic [7:0] rstv [9] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
  logic [7:0] mask [9] = '{8'h43, 8'h43, 8'h01, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'h0F, 8'h00};
  // 25 MHz clock
  always #20 clk = ~clk;
  scrb_bank #(.PULSE_CYCLES(20)) dut (.clk(clk), .rst_n(rst_n), .req(req),
    .slave_address_strap(strap), .parallel_enable_pin(pen),
    .parallel_source_pins(psrc), .rd_data_ff(rdd), .rd_valid_ff(rdv),
    .slave_address_ff(saddr), .parallel_locked_ff(locked), .link_ff(link));
  scrb_master_model mst (.clk(clk), .rd_data_ff(rdd), .rd_valid_ff(rdv), .req(req));
  function automatic logic [31:0] nxt_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt_rand
  // readback keeps only implemented bits
  function automatic logic [7:0] exp_rb(input int i, input logic [7:0] d);
    return d & mask[i];
  endfunction : exp_rb
  function automatic logic [6:0] exp_addr(input logic s);
    return {6'h24, s};
  endfunction : exp_addr
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rchk(input int i, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    mst.rd(offs[i], d, v);
    check(v, 1'b1);
    check(d, exp);
  endtask : rchk
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic close_out;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  // hang guard
  initial begin
    #(40 * 8000);
    mismatches++;
    close_out();
  end
  // main sequence
  initial begin : main
    logic [7:0] d;
    logic [7:0] e;
    logic [1:0] c;
    logic v;
    int i;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    settle(3);
    check(locked, 1'b0);
    check(link.side_source_select, psrc);
    check(link.fast_source_select, psrc);
    check(saddr, exp_addr(1'b0));
    for (i = 0; i < 9; i++) rchk(i, rstv[i]);
    check(locked, 1'b1);
    // once locked, the parallel pins no longer steer anything
    @(posedge clk);
    psrc <= 2'b10;
    settle(3);
    check(link.side_source_select, 2'b00);
    check(link.fast_source_select, 2'b00);
    // random writes with readback, selects kept off the illegal code
    for (int n = 0; n < 40; n++) begin
      lfsr = nxt_rand(lfsr);
      i = int'(lfsr[3:0]) % 9;
      d = lfsr[15:8];
      if (i < 2 && d[1:0] == 2'b11) d[1:0] = 2'b10;
      mst.wr(offs[i], d);
      rchk(i, exp_rb(i, d));
    end
    // write and read back to back on consecutive edges
    lfsr = nxt_rand(lfsr);
    mst.wr_rd(8'h13, lfsr[7:0], d, v);
    check(v, 1'b1);
    check(d, lfsr[7:0]);
    // every source code on both switches
    for (int k = 0; k < 3; k++) begin
      c = k[1:0];
      mst.wr(8'h00, {6'h10, c});
      mst.wr(8'h01, {6'h00, c});
      settle(3);
      check(link.fast_path_enable, 1'b1);
      check(link.fast_source_select, c);
      check(link.side_enable, 1'b0);
      check(link.side_source_select, c);
    end
    lfsr = nxt_rand(lfsr);
    d = lfsr[7:0];
    e = lfsr[15:8];
    mst.wr(8'h20, d);
    mst.wr(8'h13, e);
    mst.wr(8'h14, lfsr[23:16]);
    settle(3);
    check({link.output_emphasis_level, link.output_termination_enable,
      link.output_current_select}, d[3:0]);
    check(link.equalization_level_bits, {lfsr[19:16], e});
    // termination pulse on source change, then no pulse with bits clear
    mst.wr(8'h10, 8'h01);
    mst.wr(8'h11, 8'hFF);
    mst.wr(8'h12, 8'h0F);
    mst.wr(8'h00, 8'h40);
    settle(4);
    check(link.termination_connect, 12'h000);
    settle(30);
    check(link.termination_connect, 12'hFFF);
    check(link.fast_path_enable, 1'b1);
    mst.wr(8'h11, 8'h00);
    mst.wr(8'h12, 8'h00);
    mst.wr(8'h00, 8'h01);
    settle(4);
    check(link.termination_connect, 12'hFFF);
    check(link.fast_path_enable, 1'b0);
    mst.wr(8'h10, 8'h00);
    settle(3);
    check(link.termination_connect, 12'h000);
    // second reset in mid-run reopens the parallel path; strap only moves under reset
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= 1'b1;
    pen <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    settle(2);
    check(locked, 1'b0);
    check(saddr, exp_addr(1'b1));
    check(link.fast_path_enable, 1'b0);
    check(link.side_source_select, psrc);
    rchk(0, 8'h40);
    close_out();
  end
endmodule : scrb_tb_top
